// file: fault_log_pkg.sv
/*
 Fault-log register bank package: command codes, field positions, fault codes, timing.
 Assumes a 50 MHz system clock.
*/
package fault_log_pkg;

    // Register command codes
    localparam logic [7:0] PH14_LOG_CODE  = 8'hFC;
    localparam logic [7:0] PH56_LOG_CODE  = 8'hFD;
    localparam logic [7:0] SPARE_LOG_CODE = 8'hFE;

    // Field positions (low bit of each 4-bit field)
    localparam int PH_A_LSB = 12;
    localparam int PH_B_LSB = 8;
    localparam int PH_C_LSB = 4;
    localparam int PH_D_LSB = 0;
    localparam int PH_E_LSB = 12;
    localparam int PH_F_LSB = 8;

    // One-hot fault codes
    localparam logic [3:0] FAULT_NONE     = 4'h0;
    localparam logic [3:0] FAULT_VIN_SW   = 4'h1;
    localparam logic [3:0] FAULT_ILIM     = 4'h2;
    localparam logic [3:0] FAULT_OTEMP    = 4'h4;
    localparam logic [3:0] FAULT_SW_GND   = 4'h8;

    // Reset and clear values, and the second-log write mask
    localparam logic [15:0] LOG_RESET     = 16'h0000;
    localparam logic [15:0] LOG_CLEAR     = 16'h0000;
    localparam logic [15:0] PH56_WR_MASK  = 16'hFF00;

    // Settle time after a clear
    localparam int CLK_HZ       = 50_000_000;
    localparam int SETTLE_US    = 5000;
    localparam int SETTLE_CYC   = (CLK_HZ / 1_000_000) * SETTLE_US;

    // Per-phase fault report bundle
    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] c;
        logic [3:0] d;
        logic [3:0] e;
        logic [3:0] f;
    } phase_faults_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] wdata;
    } reg_req_t;

    // Settle-timer states
    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_SETTLE = 1'b1
    } settle_state_t;

endpackage

// file: fault_settle_timer.sv
/*
 Settle timer: after a clear, counts the post-clear settle time and reports busy.
 Assumes start is a one-cycle pulse on CLK_SYS.
*/
`timescale 1ns/1ps
module fault_settle_timer
    import fault_log_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic start,
    output logic      busy
);

    settle_state_t state_r;   // Timer state
    settle_state_t state_nxt;
    logic [31:0]   cnt_r;     // Cycles left
    logic [31:0]   cnt_nxt;

    // Next state: a fresh clear restarts the full interval
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE:
            begin
                if (start)
                begin
                    state_nxt = ST_SETTLE;
                    cnt_nxt   = 32'(SETTLE_CYCLES - 1);
                end
            end
            ST_SETTLE:
            begin
                if (start)
                    cnt_nxt = 32'(SETTLE_CYCLES - 1);
                else if (cnt_r == 32'h0000_0000)
                    state_nxt = ST_IDLE;
                else
                    cnt_nxt = cnt_r - 32'h0000_0001;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign busy = (state_r == ST_SETTLE);

endmodule

// file: fault_log_regs.sv
/*
 Per-phase fault-log register bank with capture on protection events.
 Assumes the management bus front end delivers decoded one-cycle read and
 write strobes with a command code on CLK_SYS, and that the protection logic
 gives a one-cycle event pulse with the phase fault reports, all synchronous.
 The settle interval after a clear is only reported; writes made while it
 runs are still accepted, so host firmware must honour the wait itself.
*/
// Operation
// - Logs keep last protection faults until cleared
// - All-zero write clears; host waits 5ms
// - Fields are 4-bit one-hot fault codes
// - Log one: phases 1-4 at 15:12..3:0
// - Log two: phases 5,6 at 15:12, 11:8
// - Reserved bits ignore writes, read zero
`timescale 1ns/1ps
module fault_log_regs
    import fault_log_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)
(
    // Clock and reset
    input  wire logic          CLK_SYS,
    input  wire logic          ARST_N,
    // Register access
    input  wire reg_req_t      REQ,
    output logic [15:0]        RDATA,
    output logic               RVALID,
    output logic               CLEAR_BUSY,
    // Protection event and power-stage reports
    input  wire logic          PROT_EVENT,
    input  wire phase_faults_t PHASE_FAULTS
);

    // Log state
    logic [15:0] log14_r;       // Phases 1 to 4
    logic [15:0] log14_nxt;
    logic [15:0] log56_r;       // Phases 5, 6 and reserved low byte
    logic [15:0] log56_nxt;
    // Answer state toward the bus front end
    logic [15:0] rdata_r;       // Read data
    logic [15:0] rdata_nxt;
    logic        rvalid_r;      // Read answer strobe
    logic        rvalid_nxt;
    logic        busy_r;        // Registered timer state
    logic        busy_nxt;
    // Control
    logic        clr_start;     // Any clear this cycle
    logic        timer_busy;    // Raw busy from the settle timer

    // Keep only legal one-hot codes; anything else is logged as none
    // Shared by all six fields so every phase decodes the same way
    function automatic logic [3:0] legal_code(input logic [3:0] c);
        case (c)
            FAULT_NONE, FAULT_VIN_SW, FAULT_ILIM, FAULT_OTEMP, FAULT_SW_GND:
                legal_code = c;
            default:
                legal_code = FAULT_NONE;
        endcase
    endfunction

    // Write decode; only an all-zero word arms the settle timer
    logic wr14;                 // Write to the phase 1 to 4 log
    logic wr56;                 // Write to the phase 5 and 6 log
    assign wr14 = REQ.wr && (REQ.code == PH14_LOG_CODE);
    assign wr56 = REQ.wr && (REQ.code == PH56_LOG_CODE);
    assign clr_start = (wr14 || wr56) && (REQ.wdata == LOG_CLEAR);

    // Log next values; an event in the clear cycle wins so it is not lost
    // A clear racing a fresh event would otherwise hide the newest fault,
    // which is the one firmware reads the log for.
    always_comb
    begin
        // Default: hold the last capture
        log14_nxt = log14_r;
        log56_nxt = log56_r;
        // Host write path; a zero word is the clear
        if (wr14)
            log14_nxt = REQ.wdata;
        // Low byte of the second log is reserved and never stored
        if (wr56)
            log56_nxt = REQ.wdata & PH56_WR_MASK;
        // Event path last, so its fields override a same-cycle write
        if (PROT_EVENT)
        begin
            // All six fields taken from one event snapshot
            log14_nxt[PH_A_LSB +: 4] = legal_code(PHASE_FAULTS.a);
            log14_nxt[PH_B_LSB +: 4] = legal_code(PHASE_FAULTS.b);
            log14_nxt[PH_C_LSB +: 4] = legal_code(PHASE_FAULTS.c);
            log14_nxt[PH_D_LSB +: 4] = legal_code(PHASE_FAULTS.d);
            log56_nxt[PH_E_LSB +: 4] = legal_code(PHASE_FAULTS.e);
            log56_nxt[PH_F_LSB +: 4] = legal_code(PHASE_FAULTS.f);
            log56_nxt[7:0]           = 8'h00;
        end
    end

    // Answer next values: read mux and busy status
    // Spare log and unknown codes read as zero; no bus error is raised
    always_comb
    begin
        rvalid_nxt = REQ.rd;
        rdata_nxt  = 16'h0000;
        busy_nxt   = timer_busy;   // One stage so the output leaves a flip-flop
        if (REQ.rd)
        begin
            case (REQ.code)
                PH14_LOG_CODE:  rdata_nxt = log14_r;
                PH56_LOG_CODE:  rdata_nxt = log56_r & PH56_WR_MASK;
                SPARE_LOG_CODE: rdata_nxt = 16'h0000;
                default:        rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Log registers; logs hold until a write or the next event
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            log14_r <= LOG_RESET;
            log56_r <= LOG_RESET;
        end
        else
        begin
            log14_r <= log14_nxt;
            log56_r <= log56_nxt;
        end
    end

    // Answer registers; RDATA is zero outside a read answer
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            busy_r   <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // Settle interval after a clear, shown to the host as a status level
    // The timer counts from the clear edge, so the output trails it by one
    fault_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk    (CLK_SYS),
        .arst_n (ARST_N),
        .start  (clr_start),
        .busy   (timer_busy)
    );

    assign RDATA      = rdata_r;
    assign RVALID     = rvalid_r;
    assign CLEAR_BUSY = busy_r;

    // Checks: all run on CLK_SYS and pause while reset is low
    // Hold and clear
    chk_log_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (!PROT_EVENT && !REQ.wr) |=> $stable(log14_r) && $stable(log56_r))
        else $error("fault log changed without cause");
    chk_clear_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (wr14 && REQ.wdata == 16'h0000 && !PROT_EVENT) |=> (log14_r == 16'h0000))
        else $error("clear write did not zero log");
    chk_busy_after: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        clr_start |=> ##1 CLEAR_BUSY)
        else $error("settle busy missing after clear");
    // Capture coding and field placement
    chk_onehot_field: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        PROT_EVENT |=> $onehot0(log14_r[15:12]) && $onehot0(log56_r[15:12]))
        else $error("captured field not one-hot");
    chk_ph_a_place: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (PROT_EVENT && $onehot0(PHASE_FAULTS.a)) |=> log14_r[15:12] == $past(PHASE_FAULTS.a))
        else $error("phase 1 field misplaced");
    chk_ph_f_place: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (PROT_EVENT && $onehot0(PHASE_FAULTS.f)) |=> log56_r[11:8] == $past(PHASE_FAULTS.f))
        else $error("phase 6 field misplaced");
    // Reserved reads and one-event snapshot
    chk_spare_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (REQ.rd && REQ.code != PH14_LOG_CODE) |=> RDATA[7:0] == 8'h00)
        else $error("reserved bits read nonzero");
    chk_event_snap: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (PROT_EVENT && $onehot0(PHASE_FAULTS.d) && $onehot0(PHASE_FAULTS.e))
        |=> log14_r[3:0] == $past(PHASE_FAULTS.d) && log56_r[15:12] == $past(PHASE_FAULTS.e))
        else $error("fields not from one event");
    // Read answers: one pulse per read, quiet bus otherwise
    chk_rvalid_pulse: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        REQ.rd |=> RVALID)
        else $error("read answer strobe missing");
    chk_rvalid_idle: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        !REQ.rd |=> !RVALID)
        else $error("read answer strobe without read");
    chk_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        !REQ.rd |=> RDATA == 16'h0000)
        else $error("read data not zero outside answer");
    chk_ph14_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (REQ.rd && REQ.code == PH14_LOG_CODE) |=> RDATA == $past(log14_r))
        else $error("phase 1 to 4 log read wrong");
    chk_ph56_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (REQ.rd && REQ.code == PH56_LOG_CODE) |=> RDATA[15:8] == $past(log56_r[15:8]))
        else $error("phase 5 and 6 log read wrong");
    chk_spare_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (REQ.rd && REQ.code == SPARE_LOG_CODE) |=> RDATA == 16'h0000)
        else $error("spare log read nonzero");
    // Reserved low byte of the second log never holds a one
    chk_low_byte: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        REQ.wr |=> log56_r[7:0] == 8'h00)
        else $error("reserved low byte stored a write");
    // Clear of the second log
    chk_clear_ph56: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (wr56 && REQ.wdata == 16'h0000 && !PROT_EVENT) |=> (log56_r == 16'h0000))
        else $error("clear write did not zero second log");
    // Event beats a write in the same cycle
    chk_event_wins: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        (PROT_EVENT && REQ.wr && $onehot0(PHASE_FAULTS.b))
        |=> log14_r[11:8] == $past(PHASE_FAULTS.b))
        else $error("write overrode a protection event");

endmodule

// file: power_stage_model.sv
/*
 Power-stage side model: raises one protection event with per-phase fault codes.
 Assumes the log bank samples the report on the rising edge of clk.
*/
`timescale 1ns/1ps
module power_stage_model
    import fault_log_pkg::*;
(
    // Clock
    input  wire logic     clk,
    // Fault report toward the log bank
    output phase_faults_t phase_faults,
    output logic          prot_event
);
    // Idle report is junk so that a stray capture shows up
    initial
    begin
        prot_event   = 1'b0;
        phase_faults = '1;
    end

    // One event, report valid only in the capture cycle
    task automatic fire(input phase_faults_t codes);
        @(negedge clk);
        prot_event   = 1'b1;
        phase_faults = codes;
        @(negedge clk);
        prot_event   = 1'b0;
        phase_faults = ~codes;  // Stale report must never look current
    endtask
endmodule

// file: phase_fault_log_registers_tb_top.sv
/*
 Testbench for the fault-log register bank: register reads and writes, events, clear.
 Assumes the design package and a shortened settle count.
*/
`timescale 1ns/1ps
module phase_fault_log_registers_tb_top
    import fault_log_pkg::*;
;
    localparam int SETTLE = 8;   // Short settle count keeps the run brief
    logic          clk_sys;
    logic          arst_n;
    reg_req_t      req;
    logic [15:0]   rdata;
    logic          rvalid;
    logic          clear_busy;
    logic          prot_event;
    phase_faults_t phase_faults;
    int            mismatches;
    int            samples_checked;
    int            n;

    fault_log_regs #(.SETTLE_CYCLES(SETTLE)) dut (
        .CLK_SYS      (clk_sys),
        .ARST_N       (arst_n),
        .REQ          (req),
        .RDATA        (rdata),
        .RVALID       (rvalid),
        .CLEAR_BUSY   (clear_busy),
        .PROT_EVENT   (prot_event),
        .PHASE_FAULTS (phase_faults)
    );

    power_stage_model stage (
        .clk          (clk_sys),
        .phase_faults (phase_faults),
        .prot_event   (prot_event)
    );

    // 50 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, code: code, wdata: data};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask

    // One-cycle read strobe, answer checked in the following cycle
    task automatic reg_read(input logic [7:0] code, input logic [15:0] exp);
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, code: code, wdata: 16'h0000};
        @(negedge clk_sys);
        req.rd = 1'b0;
        check("rvalid", {15'h0000, rvalid}, 16'h0001);
        check("rdata", rdata, exp);
    endtask

    // Single exit point
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        mismatches      = 0;
        samples_checked = 0;
        req             = '0;
        arst_n          = 1'b0;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        reg_read(PH14_LOG_CODE, LOG_RESET);
        stage.fire('{FAULT_VIN_SW, FAULT_ILIM, FAULT_OTEMP, FAULT_SW_GND, FAULT_SW_GND,
                     FAULT_OTEMP});
        repeat (3) @(negedge clk_sys);
        reg_read(PH14_LOG_CODE, 16'h1248);
        reg_read(PH56_LOG_CODE, 16'h8400);
        reg_read(SPARE_LOG_CODE, 16'h0000);
        reg_read(8'hFB, 16'h0000);
        // Codes that are not one-hot must log as no fault
        stage.fire('{4'h3, FAULT_VIN_SW, FAULT_NONE, FAULT_ILIM, FAULT_ILIM, 4'hC});
        reg_read(PH14_LOG_CODE, 16'h0102);
        reg_read(PH56_LOG_CODE, 16'h2000);
        reg_write(PH56_LOG_CODE, 16'hFFFF);
        reg_read(PH56_LOG_CODE, 16'hFF00);
        reg_write(SPARE_LOG_CODE, 16'hFFFF);
        reg_read(SPARE_LOG_CODE, 16'h0000);
        // Event and write in one cycle: the event fields win
        fork
            stage.fire('{FAULT_SW_GND, FAULT_OTEMP, FAULT_ILIM, FAULT_VIN_SW, FAULT_VIN_SW,
                         FAULT_ILIM});
            reg_write(PH14_LOG_CODE, 16'hFFFF);
        join
        reg_read(PH14_LOG_CODE, 16'h8421);
        reg_read(PH56_LOG_CODE, 16'h1200);
        // Clear, then time the settle interval
        reg_write(PH14_LOG_CODE, LOG_CLEAR);
        @(negedge clk_sys);
        check("clear_busy", {15'h0000, clear_busy}, 16'h0001);
        n = 0;
        while (clear_busy === 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("settle_len", 16'(n), 16'(SETTLE));
        reg_read(PH14_LOG_CODE, 16'h0000);
        reg_read(PH56_LOG_CODE, 16'h1200);
        reg_write(PH56_LOG_CODE, LOG_CLEAR);
        reg_read(PH56_LOG_CODE, 16'h0000);
        give_verdict();
    end

    // Hang guard, far beyond the expected run length
    initial
    begin
        #(20 * 5000);
        mismatches++;
        give_verdict();
    end
endmodule
